/* File: hdl/dma_chan_params.svh */
// Register offsets, field positions, reset values and operation list for the DMA channel
//
// Operation
// - Each transaction is one read then one write of up to four bytes.
// - Each start event moves one cell, as one or more transactions.
// - Block length is the larger of source size and destination size.
// - Source and destination start addresses and sizes are programmed independently.
// - Setting force bit 7 of event control starts a cell.
// - Selected start interrupt starts a cell when start enable bit 4 is set.
// - Channel stays on across cells until the whole block is moved.
// - A cell larger than the block moves only the block length.
// - A disabled channel refuses transfers until software sets its on bit again.
// - Half flags bits 6 and 4, done flags bits 7 and 5.
// - Writing abort bit 6 of event control cancels the pending request.
// - Pattern match cancels the request only when auto re-enable bit 4 is clear.
// - Selected abort interrupt, bits 23:16, cancels request when bit 3 enables it.
// - An address error cancels the pending request.
// - Request clears on cell end, and on block end without auto re-enable.
// - An abort sets the transfer abort flag, bit 1 of the flag register.
// - An abort lets the transaction under way finish before stopping.
// - Pointers advance after each transaction; half and done flags update then.
// - Pointers reset on reset, global off, block end, pattern end, abort write.
// - Writing a start address resets that side's pointer.
// - Address error shows in flag bit 0, block complete in flag bit 3.
// - Pattern termination and auto re-enable may act together with basic transfers.
// - A pattern match acts as block complete: sets bit 3, clears on bit 7 unless auto re-enable bit 4 is set.
`ifndef DMA_CHAN_PARAMS_SVH
`define DMA_CHAN_PARAMS_SVH

`define OFF_GLOBAL_CTL 8'h00
`define OFF_CHAN_CTL 8'h10
`define OFF_EVENT_CTL 8'h20
`define OFF_FLAGS 8'h30
`define OFF_SRC_START 8'h40
`define OFF_DST_START 8'h50
`define OFF_SRC_SIZE 8'h60
`define OFF_DST_SIZE 8'h70
`define OFF_SRC_PTR 8'h80
`define OFF_DST_PTR 8'h90
`define OFF_CELL_SIZE 8'ha0
`define OFF_CELL_PTR 8'hb0
`define OFF_PATTERN 8'hc0

`define BIT_GLOBAL_ON 15
`define BIT_CHAN_ON 7
`define BIT_AUTO_REEN 4
`define BIT_CHAN_BUSY 15
`define BIT_FORCE 7
`define BIT_ABORT 6
`define BIT_PAT_EN 5
`define BIT_START_EN 4
`define BIT_ABORT_EN 3
`define START_SEL_LSB 8
`define ABORT_SEL_LSB 16

`define FLG_ADDR_ERR 0
`define FLG_ABORT 1
`define FLG_CELL_DONE 2
`define FLG_BLOCK_DONE 3
`define FLG_DST_HALF 4
`define FLG_DST_DONE 5
`define FLG_SRC_HALF 6
`define FLG_SRC_DONE 7

`define RST_WORD 32'h0000_0000
`define WORD_BYTES 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/dma_chan_pkg.sv */
// Types shared by the DMA channel
package dma_chan_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} xfer_state_e;
  typedef logic [16:0] len_t;
endpackage

/* File: hdl/dma_channel.sv */
// DMA channel in basic transfer mode with AXI4-Lite registers and a word bus master
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dma_chan_params.svh"
module dma_channel #(
  parameter int SZW = 16,
  parameter int NIRQ = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [NIRQ-1:0] irq_lines,
  output logic mem_valid,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [2:0] mem_nbytes,
  output logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata
);
  // Size of 0 stands for 2**16 bytes
  function automatic dma_chan_pkg::len_t eff(input logic [SZW-1:0] s);
    eff = (s == '0) ? dma_chan_pkg::len_t'(17'h10000) : dma_chan_pkg::len_t'(s);
  endfunction
  function automatic dma_chan_pkg::len_t lmin(input dma_chan_pkg::len_t a,
                                             input dma_chan_pkg::len_t b);
    lmin = (a < b) ? a : b;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_full_r, w_full_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic gon_r, chan_on_r, auto_r, req_r, abort_pend_r;
  logic [31:0] econ_r, ssa_r, dsa_r;
  logic [SZW-1:0] ssz_r, dsz_r, csz_r;
  logic [7:0] pat_r, flags_r;
  dma_chan_pkg::len_t sptr_r, dptr_r, cptr_r, bcnt_r;
  dma_chan_pkg::xfer_state_e st_r;
  logic mem_valid_r, mem_write_r;
  logic [31:0] mem_addr_r, mem_wdata_r;
  logic [2:0] n_r;
  logic pat_hit_r;
  logic [NIRQ-1:0] irq_q_r;

  // AXI4-Lite write side: address and data taken in either order
  wire wr_fire = aw_full_r && w_full_r && !bvalid_r;
  wire wr_mapped = (waddr_r[3:0] == 4'h0) && (waddr_r <= `OFF_PATTERN);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      waddr_r <= 8'h00;
      wdata_r <= `RST_WORD;
      wstrb_r <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r <= (awaddr[31:8] == 24'h000000) ? awaddr[7:0] : 8'hff;
      end
      if (wvalid && wready_r) begin
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  function automatic logic hit(input logic [7:0] off);
    hit = wr_fire && (waddr_r == off);
  endfunction

  // Write decoding
  wire wr_econ = hit(`OFF_EVENT_CTL);
  wire force_wr = wr_econ && wstrb_r[0] && wdata_r[`BIT_FORCE];
  wire abort_wr = wr_econ && wstrb_r[0] && wdata_r[`BIT_ABORT];
  wire wr_ssa = hit(`OFF_SRC_START);
  wire wr_dsa = hit(`OFF_DST_START);
  wire wr_cctl = hit(`OFF_CHAN_CTL) && wstrb_r[0];

  // Interrupt lines taken on their rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q_r <= '0;
    end else begin
      irq_q_r <= irq_lines;
    end
  end
  wire [NIRQ-1:0] irq_edge = irq_lines & ~irq_q_r;
  wire start_evt = econ_r[`BIT_START_EN]
    && irq_edge[econ_r[`START_SEL_LSB +: 8]];
  wire abort_evt = econ_r[`BIT_ABORT_EN]
    && irq_edge[econ_r[`ABORT_SEL_LSB +: 8]];

  // Transfer lengths
  wire dma_chan_pkg::len_t ssz_e = eff(ssz_r);
  wire dma_chan_pkg::len_t dsz_e = eff(dsz_r);
  wire dma_chan_pkg::len_t blk_len = (ssz_e > dsz_e) ? ssz_e : dsz_e;
  wire dma_chan_pkg::len_t cell_len = lmin(eff(csz_r), blk_len);
  wire dma_chan_pkg::len_t rem_min = lmin(lmin(ssz_e - sptr_r, dsz_e - dptr_r),
                                          lmin(cell_len - cptr_r, blk_len - bcnt_r));
  wire [2:0] n_nxt = (rem_min > 17'd4) ? `WORD_BYTES : rem_min[2:0];

  // Transaction end and its results
  wire xact_done = (st_r == dma_chan_pkg::ST_WRITE) && mem_ready;
  wire rd_err = (st_r == dma_chan_pkg::ST_READ) && mem_ready && mem_err;
  wire addr_err = rd_err || (xact_done && mem_err);
  wire xact_ok = xact_done && !mem_err;
  wire dma_chan_pkg::len_t s_sum = sptr_r + dma_chan_pkg::len_t'(n_r);
  wire dma_chan_pkg::len_t d_sum = dptr_r + dma_chan_pkg::len_t'(n_r);
  wire blk_done = xact_ok && (bcnt_r + dma_chan_pkg::len_t'(n_r) == blk_len);
  wire cell_done = xact_ok && (cptr_r + dma_chan_pkg::len_t'(n_r) == cell_len);
  wire pat_end = xact_ok && pat_hit_r && econ_r[`BIT_PAT_EN];
  wire idle = (st_r == dma_chan_pkg::ST_IDLE);
  wire ptr_clr = !gon_r || blk_done || pat_end || (abort_pend_r && idle);

  // Pattern compare over the bytes actually read
  wire [3:0] lane_hit;
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_hit[g] = (g < n_r) && (mem_rdata[g*8 +: 8] == pat_r);
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gon_r <= 1'b0;
      auto_r <= 1'b0;
      econ_r <= `RST_WORD;
      ssa_r <= `RST_WORD;
      dsa_r <= `RST_WORD;
      ssz_r <= '0;
      dsz_r <= '0;
      csz_r <= '0;
      pat_r <= 8'h00;
    end else begin
      if (hit(`OFF_GLOBAL_CTL) && wstrb_r[1]) gon_r <= wdata_r[`BIT_GLOBAL_ON];
      if (wr_cctl) auto_r <= wdata_r[`BIT_AUTO_REEN];
      if (wr_econ) begin
        econ_r <= merge(econ_r, wdata_r & 32'h00ff_ff38, wstrb_r);
      end
      if (wr_ssa) ssa_r <= merge(ssa_r, wdata_r, wstrb_r);
      if (wr_dsa) dsa_r <= merge(dsa_r, wdata_r, wstrb_r);
      if (hit(`OFF_SRC_SIZE)) ssz_r <= SZW'(merge(32'(ssz_r), wdata_r, wstrb_r));
      if (hit(`OFF_DST_SIZE)) dsz_r <= SZW'(merge(32'(dsz_r), wdata_r, wstrb_r));
      if (hit(`OFF_CELL_SIZE)) csz_r <= SZW'(merge(32'(csz_r), wdata_r, wstrb_r));
      if (hit(`OFF_PATTERN) && wstrb_r[0]) pat_r <= wdata_r[7:0];
    end
  end

  // Channel on bit: software writes it; block or pattern end without auto re-enable, or an address error, clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_on_r <= 1'b0;
    end else if (wr_cctl) begin
      chan_on_r <= wdata_r[`BIT_CHAN_ON];
    end else if ((blk_done || pat_end) && !auto_r) begin
      chan_on_r <= 1'b0;
    end else if (pat_end || addr_err) begin
      chan_on_r <= pat_end ? 1'b1 : 1'b0;
    end
  end

  // Pending transfer request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= 1'b0;
    end else if (abort_wr || abort_evt || addr_err || !gon_r || !chan_on_r) begin
      req_r <= 1'b0;
    end else if (force_wr || start_evt) begin
      req_r <= 1'b1;
    end else if (cell_done || (pat_end && !auto_r)) begin
      req_r <= 1'b0;
    end
  end

  // Abort write resets pointers once the bus is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_pend_r <= 1'b0;
    end else if (abort_wr) begin
      abort_pend_r <= 1'b1;
    end else if (idle) begin
      abort_pend_r <= 1'b0;
    end
  end

  // Read then write of one word per transaction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= dma_chan_pkg::ST_IDLE;
      mem_valid_r <= 1'b0;
      mem_write_r <= 1'b0;
      mem_addr_r <= `RST_WORD;
      mem_wdata_r <= `RST_WORD;
      n_r <= 3'h0;
      pat_hit_r <= 1'b0;
    end else begin
      case (st_r)
        dma_chan_pkg::ST_IDLE: begin
          if (req_r && chan_on_r && gon_r && !abort_pend_r) begin
            st_r <= dma_chan_pkg::ST_READ;
            mem_valid_r <= 1'b1;
            mem_write_r <= 1'b0;
            mem_addr_r <= ssa_r + 32'(sptr_r);
            n_r <= n_nxt;
          end
        end
        dma_chan_pkg::ST_READ: begin
          if (mem_ready) begin
            mem_valid_r <= !mem_err;
            mem_write_r <= !mem_err;
            mem_addr_r <= dsa_r + 32'(dptr_r);
            mem_wdata_r <= mem_rdata;
            pat_hit_r <= |lane_hit;
            st_r <= mem_err ? dma_chan_pkg::ST_IDLE : dma_chan_pkg::ST_WRITE;
          end
        end
        dma_chan_pkg::ST_WRITE: begin
          if (mem_ready) begin
            mem_valid_r <= 1'b0;
            mem_write_r <= 1'b0;
            st_r <= dma_chan_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= dma_chan_pkg::ST_IDLE;
          mem_valid_r <= 1'b0;
        end
      endcase
    end
  end

  // Source, destination, cell and block progress
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sptr_r <= '0;
      dptr_r <= '0;
      cptr_r <= '0;
      bcnt_r <= '0;
    end else begin
      if (ptr_clr) begin
        sptr_r <= '0;
        dptr_r <= '0;
        bcnt_r <= '0;
      end else if (xact_ok) begin
        sptr_r <= (s_sum == ssz_e) ? '0 : s_sum;
        dptr_r <= (d_sum == dsz_e) ? '0 : d_sum;
        bcnt_r <= bcnt_r + dma_chan_pkg::len_t'(n_r);
      end
      if (wr_ssa) sptr_r <= '0;
      if (wr_dsa) dptr_r <= '0;
      if (cell_done || ptr_clr || !req_r) cptr_r <= '0;
      else if (xact_ok) cptr_r <= cptr_r + dma_chan_pkg::len_t'(n_r);
    end
  end

  // Flags: hardware set wins over a write-1-to-clear in the same cycle
  logic [7:0] flg_set, flg_clr;
  always_comb begin
    flg_clr = (hit(`OFF_FLAGS) && wstrb_r[0]) ? wdata_r[7:0] : 8'h00;
    flg_set = 8'h00;
    flg_set[`FLG_ADDR_ERR] = addr_err;
    flg_set[`FLG_ABORT] = abort_evt || abort_wr;
    flg_set[`FLG_CELL_DONE] = cell_done;
    flg_set[`FLG_BLOCK_DONE] = blk_done || pat_end;
    flg_set[`FLG_SRC_DONE] = xact_ok && (s_sum == ssz_e);
    flg_set[`FLG_DST_DONE] = xact_ok && (d_sum == dsz_e);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= (flags_r & ~flg_clr) | flg_set;
      if (xact_ok) begin
        flags_r[`FLG_SRC_HALF] <= s_sum >= (ssz_e >> 1);
        flags_r[`FLG_DST_HALF] <= d_sum >= (dsz_e >> 1);
      end
    end
  end

  // Read mux
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = (araddr[31:8] == 24'h000000) && (araddr[3:0] == 4'h0);
    case (araddr[7:0])
      `OFF_GLOBAL_CTL: rd_val = 32'(gon_r) << `BIT_GLOBAL_ON;
      `OFF_CHAN_CTL: rd_val = (32'(!idle || req_r) << `BIT_CHAN_BUSY)
        | (32'(chan_on_r) << `BIT_CHAN_ON) | (32'(auto_r) << `BIT_AUTO_REEN);
      `OFF_EVENT_CTL: rd_val = econ_r;
      `OFF_FLAGS: rd_val = 32'(flags_r);
      `OFF_SRC_START: rd_val = ssa_r;
      `OFF_DST_START: rd_val = dsa_r;
      `OFF_SRC_SIZE: rd_val = 32'(ssz_r);
      `OFF_DST_SIZE: rd_val = 32'(dsz_r);
      `OFF_SRC_PTR: rd_val = 32'(sptr_r);
      `OFF_DST_PTR: rd_val = 32'(dptr_r);
      `OFF_CELL_SIZE: rd_val = 32'(csz_r);
      `OFF_CELL_PTR: rd_val = 32'(cptr_r);
      `OFF_PATTERN: rd_val = 32'(pat_r);
      default: begin
        rd_val = `RST_WORD;
        rd_ok = 1'b0;
      end
    endcase
  end

  // AXI4-Lite read side, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= `RST_WORD;
      rresp_r <= `RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign mem_valid = mem_valid_r;
  assign mem_write = mem_write_r;
  assign mem_addr = mem_addr_r;
  assign mem_nbytes = n_r;
  assign mem_wdata = mem_wdata_r;

  // Checks
  sequence s_read_ok;
    st_r == dma_chan_pkg::ST_READ && mem_ready && !mem_err;
  endsequence
  sequence s_write_phase;
    mem_valid_r && mem_write_r && mem_addr_r == $past(dsa_r) + 32'($past(dptr_r));
  endsequence
  a_read_then_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_ok |=> s_write_phase) else $error("write did not follow read");
  a_word_bytes: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_valid_r |-> (n_r >= 3'h1 && n_r <= 3'h4)) else $error("bad byte count");
  a_force_req: assert property (@(posedge aclk) disable iff (!aresetn)
    force_wr && chan_on_r && gon_r && !abort_evt && !addr_err |=> req_r)
    else $error("force did not raise request");
  a_abort_cancel: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_wr |=> !req_r && flags_r[`FLG_ABORT]) else $error("abort missed");
  a_block_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    blk_done |=> flags_r[`FLG_BLOCK_DONE] && bcnt_r == '0) else $error("block end");
  a_off_refuses: assert property (@(posedge aclk) disable iff (!aresetn)
    idle && !chan_on_r |=> idle [*2]) else $error("transfer while off");
  a_src_ptr_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ssa |=> sptr_r == '0) else $error("source pointer kept");
  a_addr_error: assert property (@(posedge aclk) disable iff (!aresetn)
    addr_err |=> flags_r[`FLG_ADDR_ERR] && !req_r) else $error("address error");
  a_global_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !gon_r |=> sptr_r == '0 && dptr_r == '0) else $error("pointers kept");
  a_abort_finish: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_wr && st_r == dma_chan_pkg::ST_WRITE && !mem_ready |=> mem_valid_r)
    else $error("transaction cut short");
endmodule
`default_nettype wire

/* File: test/mem_model.sv */
// Byte memory on the far side of the channel bus master
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input wire logic aclk,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [2:0] mem_nbytes,
  input wire logic [31:0] mem_wdata,
  output logic mem_ready,
  output logic mem_err,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem [256];
  int n_rd = 0;
  int n_wr = 0;
  int dly = 0;
  initial begin
    mem_ready = 1'b0;
    mem_err = 1'b0;
    mem_rdata = 32'h0;
  end
  // Answers after a random wait; addresses with bit 31 set fail
  always @(posedge aclk) begin
    mem_ready <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata; // Idle data never holds the last value
    if (mem_valid && !mem_ready) begin
      if (dly != 0) begin
        dly <= dly - 1;
      end else begin
        mem_ready <= 1'b1;
        mem_err <= mem_addr[31];
        dly <= $urandom % 4;
        if (mem_write) begin
          n_wr <= n_wr + 1;
          for (int i = 0; i < mem_nbytes; i++) begin
            if (!mem_addr[31]) mem[8'(mem_addr[7:0] + i)] <= mem_wdata[8*i +: 8];
          end
        end else begin
          n_rd <= n_rd + 1;
          for (int i = 0; i < 4; i++) begin
            mem_rdata[8*i +: 8] <= mem[8'(mem_addr[7:0] + i)];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the DMA channel
`timescale 1ns/10ps
`default_nettype none
`include "dma_chan_params.svh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, mem_valid, mem_write, mem_ready, mem_err;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [31:0] rdata, mem_addr, mem_wdata, mem_rdata, rdat;
  logic [1:0] bresp, rresp, rsp;
  logic [2:0] mem_nbytes;
  logic [255:0] irq_lines = 256'h0;
  int miscompares = 0;
  int n_checks = 0;
  int nw, ss, ds, so;

  always #2 aclk = ~aclk;

  dma_channel dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .irq_lines(irq_lines), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_nbytes(mem_nbytes),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_err(mem_err), .mem_rdata(mem_rdata));

  mem_model mdl (
    .aclk(aclk), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_nbytes(mem_nbytes), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_err(mem_err), .mem_rdata(mem_rdata));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {24'h0, a};
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      rsp = bresp;
    end while (!(bvalid && bready));
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {24'h0, a};
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rdat = rdata;
    rsp = rresp;
  endtask

  task automatic poll(input logic [7:0] m);
    rdat = 32'h0;
    for (int i = 0; i < 200 && (rdat[7:0] & m) == 8'h0; i++) rd(`OFF_FLAGS);
  endtask

  task automatic pulse(input int n);
    @(posedge aclk);
    irq_lines[n] <= 1'b1;
    repeat (2) @(posedge aclk);
    irq_lines[n] <= 1'b0;
  endtask

  // Fresh random memory, then program and switch the channel on
  task automatic prog(input logic [31:0] sa, input int s, input int d, input int c);
    for (int i = 0; i < 16; i++) begin
      mdl.mem[i] = 8'($urandom);
      mdl.mem[128 + i] = 8'($urandom);
    end
    wr(`OFF_SRC_START, sa);
    wr(`OFF_DST_START, 32'h80);
    wr(`OFF_SRC_SIZE, 32'(s));
    wr(`OFF_DST_SIZE, 32'(d));
    wr(`OFF_CELL_SIZE, 32'(c));
    wr(`OFF_FLAGS, 32'hff);
    wr(`OFF_EVENT_CTL, `RST_WORD);
    wr(`OFF_CHAN_CTL, 32'h1 << `BIT_CHAN_ON);
  endtask

  // Destination holds the source repeated over the longer size
  task automatic chk_copy(input int o, input int s, input int d);
    logic [7:0] ex [16];
    for (int i = 0; i < (s > d ? s : d); i++) ex[i % d] = mdl.mem[o + i % s];
    for (int i = 0; i < d; i++) chk("dst_byte", {24'h0, mdl.mem[128 + i]}, {24'h0, ex[i]});
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(93142));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_DST_PTR);
    chk("dptr_rst", rdat, `RST_WORD);
    rd(8'hf0);
    chk("unmapped", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(8'hf0, 32'h0);
    chk("unmapped_wr", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`OFF_GLOBAL_CTL, 32'h1 << `BIT_GLOBAL_ON);
    // Whole blocks, random sizes, cell larger than block
    for (int k = 0; k < 5; k++) begin
      ss = (k == 0) ? 1 : 1 + $urandom % 12;
      ds = 1 + $urandom % 12;
      so = $urandom % 4;
      prog(32'(so), ss, ds, 16'hffff);
      wr(`OFF_EVENT_CTL, 32'h1 << `BIT_FORCE);
      poll(8'h08);
      chk("blk_flags", rdat & 32'ha8, 32'ha8);
      chk_copy(so, ss, ds);
      rd(`OFF_SRC_PTR);
      chk("sptr_blk", rdat, `RST_WORD);
      rd(`OFF_CHAN_CTL);
      chk("chan_off", {31'h0, rdat[`BIT_CHAN_ON]}, 32'h0);
    end
    nw = mdl.n_wr;
    wr(`OFF_EVENT_CTL, 32'h1 << `BIT_FORCE);
    repeat (30) @(posedge aclk);
    chk("refused", 32'(mdl.n_wr), 32'(nw));
    // Two cells of four: force, then the selected interrupt
    prog(32'h0, 8, 8, 4);
    wr(`OFF_EVENT_CTL, 32'h1 << `BIT_FORCE);
    poll(8'h04);
    chk("cell_flags", rdat & 32'h5c, 32'h54);
    rd(`OFF_SRC_PTR);
    chk("sptr_cell", rdat, 32'h4);
    rd(`OFF_CHAN_CTL);
    chk("chan_on", {31'h0, rdat[`BIT_CHAN_ON]}, 32'h1);
    wr(`OFF_EVENT_CTL, (32'd5 << `START_SEL_LSB) | (32'h1 << `BIT_START_EN));
    pulse(6);
    repeat (20) @(posedge aclk);
    rd(`OFF_DST_PTR);
    chk("other_irq", rdat, 32'h4);
    pulse(5);
    poll(8'h08);
    chk_copy(0, 8, 8);
    // Abort write during a cell
    prog(32'h0, 16, 16, 16);
    wr(`OFF_EVENT_CTL, 32'h1 << `BIT_FORCE);
    wr(`OFF_EVENT_CTL, 32'h1 << `BIT_ABORT);
    repeat (40) @(posedge aclk);
    chk("txn_whole", 32'(mdl.n_wr), 32'(mdl.n_rd));
    rd(`OFF_FLAGS);
    chk("abort_flags", rdat & 32'h0a, 32'h02);
    rd(`OFF_SRC_PTR);
    chk("sptr_abort", rdat, `RST_WORD);
    // Abort by the selected interrupt during a forced cell
    prog(32'h0, 16, 16, 16);
    wr(`OFF_EVENT_CTL, (32'd9 << `ABORT_SEL_LSB) | (32'h1 << `BIT_ABORT_EN)
      | (32'h1 << `BIT_FORCE));
    pulse(9);
    repeat (40) @(posedge aclk);
    chk("txn_whole2", 32'(mdl.n_wr), 32'(mdl.n_rd));
    rd(`OFF_FLAGS);
    chk("abort_evt", rdat & 32'h0a, 32'h02);
    wr(`OFF_SRC_START, 32'h0);
    rd(`OFF_SRC_PTR);
    chk("sptr_start", rdat, `RST_WORD);
    wr(`OFF_GLOBAL_CTL, `RST_WORD);
    rd(`OFF_DST_PTR);
    chk("dptr_off", rdat, `RST_WORD);
    wr(`OFF_GLOBAL_CTL, 32'h1 << `BIT_GLOBAL_ON);
    // Pattern byte in the second word ends the block early
    prog(32'h0, 16, 16, 16);
    for (int i = 0; i < 4; i++) mdl.mem[i] = mdl.mem[i] & 8'h7f;
    mdl.mem[5] = 8'ha5;
    nw = mdl.n_wr;
    wr(`OFF_PATTERN, 32'ha5);
    wr(`OFF_EVENT_CTL, (32'h1 << `BIT_PAT_EN) | (32'h1 << `BIT_FORCE));
    poll(8'h08);
    chk("pat_flags", rdat & 32'h88, 32'h08);
    chk("pat_xacts", 32'(mdl.n_wr - nw), 32'h2);
    chk("pat_byte", {24'h0, mdl.mem[133]}, 32'ha5);
    rd(`OFF_CHAN_CTL);
    chk("pat_off", rdat & 32'h8080, 32'h0);
    rd(`OFF_SRC_PTR);
    chk("sptr_pat", rdat, `RST_WORD);
    // Auto re-enable keeps the channel on after its block
    prog(32'h0, 4, 4, 4);
    wr(`OFF_CHAN_CTL, (32'h1 << `BIT_CHAN_ON) | (32'h1 << `BIT_AUTO_REEN));
    wr(`OFF_EVENT_CTL, 32'h1 << `BIT_FORCE);
    poll(8'h08);
    rd(`OFF_CHAN_CTL);
    chk("auto_on", rdat & 32'h8090, 32'h0090);
    // Failing source read
    prog(32'h8000_0000, 4, 4, 4);
    nw = mdl.n_wr;
    wr(`OFF_EVENT_CTL, 32'h1 << `BIT_FORCE);
    poll(8'h01);
    chk("addr_err", rdat & 32'h09, 32'h01);
    chk("no_write", 32'(mdl.n_wr), 32'(nw));
    rd(`OFF_CHAN_CTL);
    chk("err_off", {31'h0, rdat[`BIT_CHAN_ON]}, 32'h0);
    summarize();
  end

  // Watchdog after 50000 clock cycles, far beyond the expected run
  initial begin
    #(50000 * 4);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
